// file: verilog/plc_config_bank.sv
// Configuration register bank of the converter controller.
// Assumes the serial front end presents one byte command per cycle.
`timescale 1ns/1ps

module plc_config_bank
  import plc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire plc_cmd_t          cmd_i,
  input  wire logic [9:0]        vout_code_i,
  input  wire logic [9:0]        vin_code_i,
  input  wire logic              ov_detect_i,
  input  wire logic              ov_tick_i,
  input  wire logic signed [9:0] reg_error_i,
  output logic      [7:0]        rd_data_o,
  output logic                   rd_valid_o,
  output plc_cfg_t               cfg_o,
  output logic      [4:0]        mirror_gain_x10_o,
  output logic                   bias_sample_allow_o,
  output logic                   ov_confirmed_o,
  output logic signed [9:0]      reg_error_o
);

  typedef struct packed {
    plc_cfg_t          cfg;
    logic [7:0]        rd_data;
    logic              rd_valid;
    logic [4:0]        gain_x10;
    logic              sample_allow;
    logic [5:0]        ov_cnt;
    logic              ov_confirmed;
    logic signed [9:0] error_out;
  } plc_state_t;

  plc_state_t state_r;
  plc_state_t state_nxt;

  logic signed [10:0] delta_s;
  logic signed [10:0] err_abs;

  always_comb begin
    state_nxt = state_r;
    delta_s = $signed({1'b0, vout_code_i}) - $signed({1'b0, vin_code_i});
    err_abs = reg_error_i[9] ? -$signed({reg_error_i[9], reg_error_i})
                             : $signed({reg_error_i[9], reg_error_i});
    state_nxt.rd_valid = cmd_i.rd_en;

    // Write path; upper unimplemented bits are dropped here
    if (cmd_i.wr_en) begin
      case (cmd_i.addr)
        OFS_SYSTEM_CFG: begin
          state_nxt.cfg.burst_stage_sync_enable = cmd_i.wr_data[CFG_BURST_SYNC];
          state_nxt.cfg.run_enable = cmd_i.wr_data[CFG_RUN];
          state_nxt.cfg.resonant_stage_enable = cmd_i.wr_data[CFG_RESONANT];
          state_nxt.cfg.load_based_target_enable = cmd_i.wr_data[CFG_LOAD_TARGET];
          state_nxt.cfg.input_cap_current_comp_enable = cmd_i.wr_data[CFG_CAP_COMP];
          state_nxt.cfg.dither_enable = cmd_i.wr_data[CFG_DITHER];
          state_nxt.cfg.valley_turnon_enable = cmd_i.wr_data[CFG_VALLEY];
        end
        OFS_SLEEP_RATE_LO: state_nxt.cfg.sleep_sample_rate[7:0] = cmd_i.wr_data;
        OFS_SLEEP_RATE_HI: state_nxt.cfg.sleep_sample_rate[9:8] = cmd_i.wr_data[1:0];
        OFS_PEAK_POINT:    state_nxt.cfg.peak_sample_point = cmd_i.wr_data[3:0];
        OFS_OPEN_HIGH:     state_nxt.cfg.open_loop_high_level = cmd_i.wr_data[6:0];
        OFS_OPEN_LOW:      state_nxt.cfg.open_loop_low_level = cmd_i.wr_data[6:0];
        OFS_SOFT_TIME:     state_nxt.cfg.soft_turnon_time = cmd_i.wr_data[6:0];
        OFS_SOFT_COUNT:    state_nxt.cfg.soft_turnon_event_count = cmd_i.wr_data[3:0];
        OFS_MERGED: begin
          state_nxt.cfg.off_blank_general = cmd_i.wr_data[7:3];
          state_nxt.cfg.mirror_gain_code = cmd_i.wr_data[MRG_GAIN_LSB +: 2];
          state_nxt.cfg.bus_filter_enable = cmd_i.wr_data[MRG_FILTER_BIT];
        end
        OFS_OFF_BLANK: begin
          state_nxt.cfg.off_blank_overcurrent = cmd_i.wr_data[7:4];
          state_nxt.cfg.off_blank_current_limit = cmd_i.wr_data[3:0];
        end
        OFS_OV_BLANK:      state_nxt.cfg.overvoltage_blanking = cmd_i.wr_data[5:0];
        OFS_BURST_HYS:     state_nxt.cfg.burst_output_hysteresis = cmd_i.wr_data[5:0];
        OFS_DEAD_BAND:     state_nxt.cfg.regulation_dead_band = cmd_i.wr_data[4:0];
        OFS_PERIOD_POINT:  state_nxt.cfg.input_period_detect_point = cmd_i.wr_data[6:0];
        OFS_TOP_DETECT:    state_nxt.cfg.input_top_detect = cmd_i.wr_data[6:0];
        OFS_BOTTOM_DETECT: state_nxt.cfg.input_bottom_detect = cmd_i.wr_data[6:0];
        OFS_BIAS_CTRL: begin
          state_nxt.cfg.sense_pin_fault_response = cmd_i.wr_data[BIAS_FAULT_BIT];
          state_nxt.cfg.sense_bias_sample_enable = cmd_i.wr_data[BIAS_SAMPLE_BIT];
          state_nxt.cfg.sense_bias_trim_value = cmd_i.wr_data[5:0];
        end
        OFS_OFFSET_TRIM:   state_nxt.cfg.converter_offset_trim = cmd_i.wr_data[4:0];
        OFS_MIN_DELTA:     state_nxt.cfg.bias_sample_min_delta = cmd_i.wr_data[6:0];
        OFS_IN_FIRST:      state_nxt.cfg.bias_sample_input_first = cmd_i.wr_data[6:0];
        OFS_IN_SECOND:     state_nxt.cfg.bias_sample_input_second = cmd_i.wr_data[6:0];
        OFS_IN_THIRD:      state_nxt.cfg.bias_sample_input_third = cmd_i.wr_data[6:0];
        OFS_IN_FOURTH_LO:  state_nxt.cfg.bias_sample_input_fourth[7:0] = cmd_i.wr_data;
        OFS_IN_FOURTH_HI:  state_nxt.cfg.bias_sample_input_fourth[9:8] = cmd_i.wr_data[1:0];
        OFS_ADAPT_HYS:     state_nxt.cfg.adaptive_input_hysteresis = cmd_i.wr_data;
        OFS_VALLEY_HYS:    state_nxt.cfg.valley_input_hysteresis = cmd_i.wr_data[5:0];
        default: begin
          // Unmapped writes leave every register as it was
        end
      endcase
    end

    // Read path reflects the registers before this cycle's write
    if (cmd_i.rd_en) begin
      case (cmd_i.addr)
        OFS_SYSTEM_CFG: state_nxt.rd_data = {state_r.cfg.burst_stage_sync_enable,
                                             1'b0,
                                             state_r.cfg.run_enable,
                                             state_r.cfg.resonant_stage_enable,
                                             state_r.cfg.load_based_target_enable,
                                             state_r.cfg.input_cap_current_comp_enable,
                                             state_r.cfg.dither_enable,
                                             state_r.cfg.valley_turnon_enable};
        OFS_SLEEP_RATE_LO: state_nxt.rd_data = state_r.cfg.sleep_sample_rate[7:0];
        OFS_SLEEP_RATE_HI: state_nxt.rd_data = {6'h00, state_r.cfg.sleep_sample_rate[9:8]};
        OFS_PEAK_POINT:    state_nxt.rd_data = {4'h0, state_r.cfg.peak_sample_point};
        OFS_OPEN_HIGH:     state_nxt.rd_data = {1'b0, state_r.cfg.open_loop_high_level};
        OFS_OPEN_LOW:      state_nxt.rd_data = {1'b0, state_r.cfg.open_loop_low_level};
        OFS_SOFT_TIME:     state_nxt.rd_data = {1'b0, state_r.cfg.soft_turnon_time};
        OFS_SOFT_COUNT:    state_nxt.rd_data = {4'h0, state_r.cfg.soft_turnon_event_count};
        OFS_MERGED:        state_nxt.rd_data = {state_r.cfg.off_blank_general,
                                                state_r.cfg.mirror_gain_code,
                                                state_r.cfg.bus_filter_enable};
        OFS_OFF_BLANK:     state_nxt.rd_data = {state_r.cfg.off_blank_overcurrent,
                                                state_r.cfg.off_blank_current_limit};
        OFS_OV_BLANK:      state_nxt.rd_data = {2'h0, state_r.cfg.overvoltage_blanking};
        OFS_BURST_HYS:     state_nxt.rd_data = {2'h0, state_r.cfg.burst_output_hysteresis};
        OFS_DEAD_BAND:     state_nxt.rd_data = {3'h0, state_r.cfg.regulation_dead_band};
        OFS_PERIOD_POINT:  state_nxt.rd_data = {1'b0, state_r.cfg.input_period_detect_point};
        OFS_TOP_DETECT:    state_nxt.rd_data = {1'b0, state_r.cfg.input_top_detect};
        OFS_BOTTOM_DETECT: state_nxt.rd_data = {1'b0, state_r.cfg.input_bottom_detect};
        OFS_BIAS_CTRL:     state_nxt.rd_data = {state_r.cfg.sense_pin_fault_response,
                                                state_r.cfg.sense_bias_sample_enable,
                                                state_r.cfg.sense_bias_trim_value};
        OFS_OFFSET_TRIM:   state_nxt.rd_data = {3'h0, state_r.cfg.converter_offset_trim};
        OFS_MIN_DELTA:     state_nxt.rd_data = {1'b0, state_r.cfg.bias_sample_min_delta};
        OFS_IN_FIRST:      state_nxt.rd_data = {1'b0, state_r.cfg.bias_sample_input_first};
        OFS_IN_SECOND:     state_nxt.rd_data = {1'b0, state_r.cfg.bias_sample_input_second};
        OFS_IN_THIRD:      state_nxt.rd_data = {1'b0, state_r.cfg.bias_sample_input_third};
        OFS_IN_FOURTH_LO:  state_nxt.rd_data = state_r.cfg.bias_sample_input_fourth[7:0];
        OFS_IN_FOURTH_HI:  state_nxt.rd_data = {6'h00, state_r.cfg.bias_sample_input_fourth[9:8]};
        OFS_ADAPT_HYS:     state_nxt.rd_data = state_r.cfg.adaptive_input_hysteresis;
        OFS_VALLEY_HYS:    state_nxt.rd_data = {2'h0, state_r.cfg.valley_input_hysteresis};
        default:           state_nxt.rd_data = 8'h00;
      endcase
    end

    // Mirror gain in tenths for the analog trim
    case (state_r.cfg.mirror_gain_code)
      2'b00:   state_nxt.gain_x10 = GAIN_X10_C0;
      2'b01:   state_nxt.gain_x10 = GAIN_X10_C1;
      2'b10:   state_nxt.gain_x10 = GAIN_X10_C2;
      default: state_nxt.gain_x10 = GAIN_X10_C3;
    endcase

    // Negative headroom never qualifies a bias sample
    state_nxt.sample_allow = state_r.cfg.sense_bias_sample_enable
                           && !delta_s[10]
                           && (delta_s >= $signed({4'h0, state_r.cfg.bias_sample_min_delta}));

    // Overvoltage qualified only after the blanking ticks elapse
    if (!ov_detect_i) begin
      state_nxt.ov_cnt = 6'h00;
      state_nxt.ov_confirmed = 1'b0;
    end else if (state_r.ov_cnt >= state_r.cfg.overvoltage_blanking) begin
      state_nxt.ov_confirmed = 1'b1;
    end else if (ov_tick_i) begin
      state_nxt.ov_cnt = state_r.ov_cnt + 6'h01;
    end

    // Dead band squashes small errors to zero
    if (err_abs <= $signed({6'h00, state_r.cfg.regulation_dead_band})) begin
      state_nxt.error_out = 10'sh000;
    end else begin
      state_nxt.error_out = reg_error_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r <= '0;
      state_r.cfg.burst_stage_sync_enable <= RST_SYSTEM_CFG[CFG_BURST_SYNC];
      state_r.cfg.run_enable <= RST_SYSTEM_CFG[CFG_RUN];
      state_r.cfg.resonant_stage_enable <= RST_SYSTEM_CFG[CFG_RESONANT];
      state_r.cfg.load_based_target_enable <= RST_SYSTEM_CFG[CFG_LOAD_TARGET];
      state_r.cfg.input_cap_current_comp_enable <= RST_SYSTEM_CFG[CFG_CAP_COMP];
      state_r.cfg.dither_enable <= RST_SYSTEM_CFG[CFG_DITHER];
      state_r.cfg.valley_turnon_enable <= RST_SYSTEM_CFG[CFG_VALLEY];
      state_r.cfg.sleep_sample_rate <= RST_SLEEP_RATE;
      state_r.cfg.peak_sample_point <= RST_PEAK_POINT;
      state_r.cfg.open_loop_high_level <= RST_OPEN_HIGH;
      state_r.cfg.open_loop_low_level <= RST_OPEN_LOW;
      state_r.cfg.soft_turnon_time <= RST_SOFT_TIME;
      state_r.cfg.soft_turnon_event_count <= RST_SOFT_COUNT;
      state_r.cfg.off_blank_general <= RST_MERGED[7:3];
      state_r.cfg.mirror_gain_code <= RST_MERGED[MRG_GAIN_LSB +: 2];
      state_r.cfg.bus_filter_enable <= RST_MERGED[MRG_FILTER_BIT];
      state_r.cfg.off_blank_overcurrent <= RST_OFF_BLANK[7:4];
      state_r.cfg.off_blank_current_limit <= RST_OFF_BLANK[3:0];
      state_r.cfg.overvoltage_blanking <= RST_OV_BLANK;
      state_r.cfg.burst_output_hysteresis <= RST_BURST_HYS;
      state_r.cfg.regulation_dead_band <= RST_DEAD_BAND;
      state_r.cfg.input_period_detect_point <= RST_PERIOD_POINT;
      state_r.cfg.input_top_detect <= RST_TOP_DETECT;
      state_r.cfg.input_bottom_detect <= RST_BOTTOM_DETECT;
      state_r.cfg.sense_pin_fault_response <= RST_BIAS_CTRL[BIAS_FAULT_BIT];
      state_r.cfg.sense_bias_sample_enable <= RST_BIAS_CTRL[BIAS_SAMPLE_BIT];
      state_r.cfg.sense_bias_trim_value <= RST_BIAS_CTRL[5:0];
      state_r.cfg.converter_offset_trim <= RST_OFFSET_TRIM;
      state_r.cfg.bias_sample_min_delta <= RST_MIN_DELTA;
      state_r.cfg.bias_sample_input_first <= RST_IN_FIRST;
      state_r.cfg.bias_sample_input_second <= RST_IN_SECOND;
      state_r.cfg.bias_sample_input_third <= RST_IN_THIRD;
      state_r.cfg.bias_sample_input_fourth <= RST_IN_FOURTH;
      state_r.cfg.adaptive_input_hysteresis <= RST_ADAPT_HYS;
      state_r.cfg.valley_input_hysteresis <= RST_VALLEY_HYS;
      state_r.gain_x10 <= GAIN_X10_C0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data_o           = state_r.rd_data;
  assign rd_valid_o          = state_r.rd_valid;
  assign cfg_o               = state_r.cfg;
  assign mirror_gain_x10_o   = state_r.gain_x10;
  assign bias_sample_allow_o = state_r.sample_allow;
  assign ov_confirmed_o      = state_r.ov_confirmed;
  assign reg_error_o         = state_r.error_out;

endmodule

// file: verilog/plc_pkg.sv
// Constants and types for the converter configuration register bank.
// Assumes a byte-wide command port driven by the serial bus front end.
// Function
// - Config bit7 syncs correction stage burst to resonant
// - Config bit5 is master run control
// - Config bit4 enables resonant stage
// - Config bit3 selects load-based output target
// - Config bit2 enables input capacitor current compensation
// - Config bit1 enables switching frequency dithering
// - Config bit0 enables valley-synchronised turn-on
// - Ten-bit sample rate used while switching off
// - Bits 2:1 select current mirror gain
// - Bias bit7 picks hiccup or latched sense fault
// - Bias bit6 enables power-on bias sampling
// - Bias sample only when delta meets minimum
// - Seven-bit soft turn-on time after overvoltage
// - Four-bit soft turn-on switching event count
// - Six-bit blanking before acting on overvoltage
// - Separate overcurrent and current limit off blanking
// - Six-bit burst output hysteresis band
// - Errors inside dead band treated as zero
// - Wide values span two bytes, high upper
// - Bits above implemented width are read-only
package plc_pkg;

  localparam logic [7:0] OFS_SYSTEM_CFG    = 8'h56;
  localparam logic [7:0] OFS_SLEEP_RATE_LO = 8'h57;
  localparam logic [7:0] OFS_SLEEP_RATE_HI = 8'h58;
  localparam logic [7:0] OFS_PEAK_POINT    = 8'h59;
  localparam logic [7:0] OFS_OPEN_HIGH     = 8'h5A;
  localparam logic [7:0] OFS_OPEN_LOW      = 8'h5B;
  localparam logic [7:0] OFS_SOFT_TIME     = 8'h5C;
  localparam logic [7:0] OFS_SOFT_COUNT    = 8'h5D;
  localparam logic [7:0] OFS_MERGED        = 8'h5E;
  localparam logic [7:0] OFS_OFF_BLANK     = 8'h5F;
  localparam logic [7:0] OFS_OV_BLANK      = 8'h60;
  localparam logic [7:0] OFS_BURST_HYS     = 8'h61;
  localparam logic [7:0] OFS_DEAD_BAND     = 8'h62;
  localparam logic [7:0] OFS_PERIOD_POINT  = 8'h63;
  localparam logic [7:0] OFS_TOP_DETECT    = 8'h64;
  localparam logic [7:0] OFS_BOTTOM_DETECT = 8'h65;
  localparam logic [7:0] OFS_BIAS_CTRL     = 8'h66;
  localparam logic [7:0] OFS_OFFSET_TRIM   = 8'h67;
  localparam logic [7:0] OFS_MIN_DELTA     = 8'h68;
  localparam logic [7:0] OFS_IN_FIRST      = 8'h69;
  localparam logic [7:0] OFS_IN_SECOND     = 8'h6A;
  localparam logic [7:0] OFS_IN_THIRD      = 8'h6B;
  localparam logic [7:0] OFS_IN_FOURTH_LO  = 8'h6C;
  localparam logic [7:0] OFS_IN_FOURTH_HI  = 8'h6D;
  localparam logic [7:0] OFS_ADAPT_HYS     = 8'h6E;
  localparam logic [7:0] OFS_VALLEY_HYS    = 8'h6F;

  // Config bit positions
  localparam int CFG_BURST_SYNC  = 7;
  localparam int CFG_RESERVED    = 6;
  localparam int CFG_RUN         = 5;
  localparam int CFG_RESONANT    = 4;
  localparam int CFG_LOAD_TARGET = 3;
  localparam int CFG_CAP_COMP    = 2;
  localparam int CFG_DITHER      = 1;
  localparam int CFG_VALLEY      = 0;
  // Bias control and merged register positions
  localparam int BIAS_FAULT_BIT  = 7;
  localparam int BIAS_SAMPLE_BIT = 6;
  localparam int MRG_FILTER_BIT  = 0;
  localparam int MRG_GAIN_LSB    = 1;

  localparam logic [7:0] RST_SYSTEM_CFG    = 8'h34;
  localparam logic [9:0] RST_SLEEP_RATE    = 10'h320;
  localparam logic [3:0] RST_PEAK_POINT    = 4'h2;
  localparam logic [6:0] RST_OPEN_HIGH     = 7'h5C;
  localparam logic [6:0] RST_OPEN_LOW      = 7'h3D;
  localparam logic [6:0] RST_SOFT_TIME     = 7'h28;
  localparam logic [3:0] RST_SOFT_COUNT    = 4'h7;
  localparam logic [7:0] RST_MERGED        = 8'h21;
  localparam logic [7:0] RST_OFF_BLANK     = 8'h35;
  localparam logic [5:0] RST_OV_BLANK      = 6'h32;
  localparam logic [5:0] RST_BURST_HYS     = 6'h0A;
  localparam logic [4:0] RST_DEAD_BAND     = 5'h00;
  localparam logic [6:0] RST_PERIOD_POINT  = 7'h52;
  localparam logic [6:0] RST_TOP_DETECT    = 7'h14;
  localparam logic [6:0] RST_BOTTOM_DETECT = 7'h3D;
  localparam logic [7:0] RST_BIAS_CTRL     = 8'h00;
  localparam logic [4:0] RST_OFFSET_TRIM   = 5'h00;
  localparam logic [6:0] RST_MIN_DELTA     = 7'h29;
  localparam logic [6:0] RST_IN_FIRST      = 7'h14;
  localparam logic [6:0] RST_IN_SECOND     = 7'h29;
  localparam logic [6:0] RST_IN_THIRD      = 7'h3D;
  localparam logic [9:0] RST_IN_FOURTH     = 10'h133;
  localparam logic [7:0] RST_ADAPT_HYS     = 8'h05;
  localparam logic [5:0] RST_VALLEY_HYS    = 6'h14;

  // Mirror gain in tenths, indexed by the two-bit code
  localparam logic [4:0] GAIN_X10_C0 = 5'h0A;
  localparam logic [4:0] GAIN_X10_C1 = 5'h0E;
  localparam logic [4:0] GAIN_X10_C2 = 5'h10;
  localparam logic [4:0] GAIN_X10_C3 = 5'h14;

  typedef struct packed {
    logic       burst_stage_sync_enable;
    logic       run_enable;
    logic       resonant_stage_enable;
    logic       load_based_target_enable;
    logic       input_cap_current_comp_enable;
    logic       dither_enable;
    logic       valley_turnon_enable;
    logic [9:0] sleep_sample_rate;
    logic [3:0] peak_sample_point;
    logic [6:0] open_loop_high_level;
    logic [6:0] open_loop_low_level;
    logic [6:0] soft_turnon_time;
    logic [3:0] soft_turnon_event_count;
    logic [4:0] off_blank_general;
    logic [1:0] mirror_gain_code;
    logic       bus_filter_enable;
    logic [3:0] off_blank_overcurrent;
    logic [3:0] off_blank_current_limit;
    logic [5:0] overvoltage_blanking;
    logic [5:0] burst_output_hysteresis;
    logic [4:0] regulation_dead_band;
    logic [6:0] input_period_detect_point;
    logic [6:0] input_top_detect;
    logic [6:0] input_bottom_detect;
    logic       sense_pin_fault_response;
    logic       sense_bias_sample_enable;
    logic [5:0] sense_bias_trim_value;
    logic [4:0] converter_offset_trim;
    logic [6:0] bias_sample_min_delta;
    logic [6:0] bias_sample_input_first;
    logic [6:0] bias_sample_input_second;
    logic [6:0] bias_sample_input_third;
    logic [9:0] bias_sample_input_fourth;
    logic [7:0] adaptive_input_hysteresis;
    logic [5:0] valley_input_hysteresis;
  } plc_cfg_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
  } plc_cmd_t;

endpackage

// file: testbench/plc_host_model.sv
// Serial host stand-in: issues byte writes and reads on the command port.
// Assumes one command per call and a read answer registered on the same edge that takes it.
`timescale 1ns/1ps
module plc_host_model
  import plc_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output plc_cmd_t        cmd_o
);
  initial cmd_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cmd_o <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: d};
    @(posedge ref_clk_i);
    cmd_o <= '0;
  endtask
  // Missing answer shows as unknown so a compare cannot pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    cmd_o <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: ~a};
    @(posedge ref_clk_i);
    cmd_o <= '0;
    @(negedge ref_clk_i);
    d = rd_valid_i ? rd_data_i : 8'hXX;
  endtask
endmodule

// file: testbench/plc_cb_checker.sv
// Port assertions for the configuration register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module plc_cb_checker
  import plc_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire plc_cmd_t          cmd_i,
  input wire logic [9:0]        vout_code_i,
  input wire logic [9:0]        vin_code_i,
  input wire logic              ov_detect_i,
  input wire logic              ov_tick_i,
  input wire logic signed [9:0] reg_error_i,
  input wire logic [7:0]        rd_data_o,
  input wire logic              rd_valid_o,
  input wire plc_cfg_t          cfg_o,
  input wire logic [4:0]        mirror_gain_x10_o,
  input wire logic              bias_sample_allow_o,
  input wire logic              ov_confirmed_o,
  input wire logic signed [9:0] reg_error_o
);
  localparam logic [4:0] GTAB [4] = '{5'h0A, 5'h0E, 5'h10, 5'h14};
  logic signed [10:0] e_x;
  logic signed [10:0] e_abs;
  logic               in_band;
  logic               allow_exp;
  logic               cfg_wr;
  assign e_x = {reg_error_i[9], reg_error_i};
  // Eleven bits so the most negative error has a magnitude
  assign e_abs = (e_x < 0) ? -e_x : e_x;
  assign in_band = e_abs <= $signed({6'h00, cfg_o.regulation_dead_band});
  assign allow_exp = cfg_o.sense_bias_sample_enable &&
    ({1'b0, vout_code_i} >= {1'b0, vin_code_i} + {4'h0, cfg_o.bias_sample_min_delta});
  assign cfg_wr = cmd_i.wr_en && cmd_i.addr == OFS_SYSTEM_CFG;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_cfg_run_sync: assert property (cfg_wr |=>
    {cfg_o.burst_stage_sync_enable, cfg_o.run_enable} == {$past(cmd_i.wr_data[7]),
    $past(cmd_i.wr_data[5])}) else $error("config run or sync bit wrong");
  a_cfg_stage_valley: assert property (cfg_wr |=>
    {cfg_o.resonant_stage_enable, cfg_o.valley_turnon_enable} ==
    {$past(cmd_i.wr_data[4]), $past(cmd_i.wr_data[0])}) else $error("config bit wrong");
  a_reserved_reads_zero: assert property (cmd_i.rd_en && cmd_i.addr == OFS_SYSTEM_CFG |=>
    rd_valid_o && !rd_data_o[6] && rd_data_o[5] == $past(cfg_o.run_enable))
    else $error("config readback wrong");
  a_wide_high_byte: assert property (cmd_i.wr_en && cmd_i.addr == OFS_IN_FOURTH_HI |=>
    cfg_o.bias_sample_input_fourth[9:8] == $past(cmd_i.wr_data[1:0]))
    else $error("wide value high byte wrong");
  a_gain_map: assert property (!$past(reset_i) |->
    mirror_gain_x10_o == GTAB[$past(cfg_o.mirror_gain_code)]) else $error("gain wrong");
  a_bias_allow: assert property (!$past(reset_i) |->
    bias_sample_allow_o == $past(allow_exp)) else $error("bias allow wrong");
  a_dead_band: assert property (!$past(reset_i) |-> reg_error_o ==
    ($past(in_band) ? 10'sh000 : $past(reg_error_i))) else $error("dead band wrong");
  a_ov_clears: assert property (!ov_detect_i |=> !ov_confirmed_o)
    else $error("overvoltage flag held");
  a_ov_cause: assert property ($rose(ov_confirmed_o) |-> $past(ov_detect_i))
    else $error("overvoltage flag without detect");
  c_ov: cover property ($rose(ov_confirmed_o));
  c_allow: cover property ($rose(bias_sample_allow_o));
  c_read: cover property (rd_valid_o);
endmodule
bind plc_config_bank plc_cb_checker chk_u (.ref_clk_i, .reset_i, .cmd_i, .vout_code_i,
  .vin_code_i, .ov_detect_i, .ov_tick_i, .reg_error_i, .rd_data_o, .rd_valid_o, .cfg_o,
  .mirror_gain_x10_o, .bias_sample_allow_o, .ov_confirmed_o, .reg_error_o);

// file: testbench/plc_config_bank_tb.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module plc_config_bank_tb
  import plc_pkg::*;
;
  localparam logic [7:0] RST_T [26] = '{8'h34, 8'h20, 8'h03, 8'h02, 8'h5C, 8'h3D, 8'h28,
    8'h07, 8'h21, 8'h35, 8'h32, 8'h0A, 8'h00, 8'h52, 8'h14, 8'h3D, 8'h00, 8'h00, 8'h29,
    8'h14, 8'h29, 8'h3D, 8'h33, 8'h01, 8'h05, 8'h14};
  localparam logic [7:0] MSK_T [26] = '{8'hBF, 8'hFF, 8'h03, 8'h0F, 8'h7F, 8'h7F, 8'h7F,
    8'h0F, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h1F, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h1F, 8'h7F,
    8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h03, 8'hFF, 8'h3F};
  localparam logic [4:0] GAIN_T [4] = '{5'h0A, 5'h0E, 5'h10, 5'h14};
  logic              ref_clk_i = 1'b0;
  logic              reset_i = 1'b1;
  plc_cmd_t          cmd;
  logic [9:0]        vout_code_i = 10'h000;
  logic [9:0]        vin_code_i = 10'h000;
  logic              ov_detect_i = 1'b0;
  logic              ov_tick_i = 1'b0;
  logic signed [9:0] reg_error_i = 10'sh000;
  logic [7:0]        rd_data;
  logic              rd_valid;
  plc_cfg_t          cfg_o;
  logic [4:0]        gain;
  logic              allow;
  logic              ov_ok;
  logic signed [9:0] err_o;
  logic [7:0]        d;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  plc_config_bank dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cmd_i(cmd),
    .vout_code_i(vout_code_i), .vin_code_i(vin_code_i), .ov_detect_i(ov_detect_i),
    .ov_tick_i(ov_tick_i), .reg_error_i(reg_error_i), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .cfg_o(cfg_o), .mirror_gain_x10_o(gain),
    .bias_sample_allow_o(allow), .ov_confirmed_o(ov_ok), .reg_error_o(err_o));
  plc_host_model host_u (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .cmd_o(cmd));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("TB: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk_i) ov_tick_i <= 1'b1;
    @(posedge ref_clk_i) ov_tick_i <= 1'b0;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 26; i++) begin
      host_u.rd(8'(8'h56 + i), d);
      chk("reset value", 16'(d), 16'(RST_T[i]));
    end
    host_u.rd(8'h70, d);
    chk("unmapped read", 16'(d), 16'h0000);
    $display("TB: test reset done");
    for (int i = 0; i < 26; i++) host_u.wr(8'(8'h56 + i), 8'hFF);
    for (int i = 0; i < 26; i++) begin
      host_u.rd(8'(8'h56 + i), d);
      chk("writable bits", 16'(d), 16'(MSK_T[i]));
    end
    chk("soft time", 16'(cfg_o.soft_turnon_time), 16'h007F);
    chk("soft count", 16'(cfg_o.soft_turnon_event_count), 16'h000F);
    chk("blank pair", 16'({cfg_o.off_blank_overcurrent, cfg_o.off_blank_current_limit}),
      16'h00FF);
    chk("burst band", 16'(cfg_o.burst_output_hysteresis), 16'h003F);
    chk("sense fault", 16'(cfg_o.sense_pin_fault_response), 16'h0001);
    $display("TB: test access done");
    for (int b = 0; b < 8; b++) begin
      host_u.wr(OFS_SYSTEM_CFG, 8'(1 << b));
      @(negedge ref_clk_i);
      chk("config bits", 16'({cfg_o.burst_stage_sync_enable, cfg_o.run_enable,
        cfg_o.resonant_stage_enable, cfg_o.load_based_target_enable,
        cfg_o.input_cap_current_comp_enable, cfg_o.dither_enable,
        cfg_o.valley_turnon_enable}), 16'({b == 7, 6'(1 << b)}));
    end
    for (int c = 0; c < 4; c++) begin
      host_u.wr(OFS_MERGED, 8'((c << 1) | (c & 1)));
      repeat (2) @(negedge ref_clk_i);
      chk("gain", 16'(gain), 16'(GAIN_T[c]));
      chk("bus filter", 16'(cfg_o.bus_filter_enable), 16'(c & 1));
    end
    host_u.wr(OFS_SLEEP_RATE_LO, 8'h11);
    host_u.wr(OFS_SLEEP_RATE_HI, 8'hFE);
    host_u.wr(OFS_IN_FOURTH_LO, 8'hAB);
    host_u.wr(OFS_IN_FOURTH_HI, 8'h02);
    @(negedge ref_clk_i);
    chk("sleep rate", 16'(cfg_o.sleep_sample_rate), 16'h0211);
    chk("fourth level", 16'(cfg_o.bias_sample_input_fourth), 16'h02AB);
    $display("TB: test fields done");
    host_u.wr(OFS_BIAS_CTRL, 8'h40);
    host_u.wr(OFS_MIN_DELTA, 8'h10);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_i);
      vout_code_i <= 10'h030;
      vin_code_i <= 10'(10'h020 + k);
      repeat (2) @(negedge ref_clk_i);
      chk("bias allow", 16'(allow), 16'(k == 0));
    end
    host_u.wr(OFS_BIAS_CTRL, 8'h00);
    vin_code_i <= 10'h000;
    repeat (2) @(negedge ref_clk_i);
    chk("bias allow off", 16'(allow), 16'h0000);
    host_u.wr(OFS_DEAD_BAND, 8'h05);
    foreach (GAIN_T[k]) begin
      @(posedge ref_clk_i) reg_error_i <= 10'(((k & 1) ? -1 : 1) * ((k < 2) ? 5 : 6));
      repeat (2) @(negedge ref_clk_i);
      chk("dead band", 16'(err_o), (k < 2) ? 16'h0000 : 16'(reg_error_i));
    end
    host_u.wr(OFS_OV_BLANK, 8'h02);
    @(posedge ref_clk_i) ov_detect_i <= 1'b1;
    tick();
    @(negedge ref_clk_i);
    chk("ov early", 16'(ov_ok), 16'h0000);
    tick();
    repeat (2) @(negedge ref_clk_i);
    chk("ov confirm", 16'(ov_ok), 16'h0001);
    @(posedge ref_clk_i) ov_detect_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk("ov release", 16'(ov_ok), 16'h0000);
    $display("TB: test behaviour done");
    tally_and_finish();
  end
endmodule
